//--- core/glm_pkg.sv
/*
  Constants shared by the genset load management block: register map,
  field positions, reset values and timing figures.
  Assumes a 100 MHz clock and an AHB-Lite master with 32-bit data.
*/
// Notes on behaviour
// - Shed output set above upper shed limit
// - Shed output cleared only below lower limit
// - Shedding always on, routable output
// - Dummy load is inverse of shed
// - Add output active below lower limit
// - Subtract output active above upper limit
// - Same-direction delay spaces like activations
// - Cross delay: subtract then add waits
// - Up to five prioritized steps
// - Connect ascending, disconnect from highest connected
// - Low for add start delay adds one step
// - High for subtract start delay removes one
// - Add wait delay between add pulses
// - Subtract wait delay between subtract pulses
// - Each step pulse lasts 0.25 s
// - Further add needs start and wait done
package glm_pkg;

  // ==========================================================================
  // Sizes
  localparam int GLM_STEPS = 5;                        // Step count
  localparam int GLM_PW = 24;                          // Power word width
  localparam int GLM_TW = 24;                          // Delay field width (ticks)

  // ==========================================================================
  // Timing
  localparam int GLM_CLK_HZ = 100000000;               // Clock rate
  localparam int GLM_TICK_US = 10000;                  // Delay tick, microseconds
  localparam int GLM_TICK_CYC = GLM_CLK_HZ / 1000000 * GLM_TICK_US;
  localparam int GLM_PULSE_MS = 250;                   // Step pulse width
  localparam int GLM_PULSE_TICKS = GLM_PULSE_MS * 1000 / GLM_TICK_US;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] GLM_A_POWER = 8'h00;          // Measured power
  localparam logic [7:0] GLM_A_SHED_HI = 8'h04;        // Upper shed limit
  localparam logic [7:0] GLM_A_SHED_LO = 8'h08;        // Lower shed limit
  localparam logic [7:0] GLM_A_SAME_DLY = 8'h0C;       // Same-direction delay
  localparam logic [7:0] GLM_A_CROSS_DLY = 8'h10;      // Subtract-to-add delay
  localparam logic [7:0] GLM_A_MADD_LVL = 8'h14;       // Multi add level
  localparam logic [7:0] GLM_A_MSUB_LVL = 8'h18;       // Multi subtract level
  localparam logic [7:0] GLM_A_MADD_START = 8'h1C;     // Multi add start delay
  localparam logic [7:0] GLM_A_MSUB_START = 8'h20;     // Multi subtract start delay
  localparam logic [7:0] GLM_A_MADD_WAIT = 8'h24;      // increase_wait_delay
  localparam logic [7:0] GLM_A_MSUB_WAIT = 8'h28;      // decrease_wait_delay
  localparam logic [7:0] GLM_A_STATUS = 8'h2C;         // Status, read only

  // ==========================================================================
  // Status fields
  localparam int GLM_ST_SHED = 0;
  localparam int GLM_ST_DUMMY = 1;
  localparam int GLM_ST_ADD = 2;
  localparam int GLM_ST_SUB = 3;
  localparam int GLM_ST_STEPS = 8;                     // Connected step mask, 5 bits

  // ==========================================================================
  // Reset values
  localparam logic [31:0] GLM_RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] GLM_RST_HI = 32'h00FF_FFFF;  // Upper limits at full scale
  localparam logic [31:0] GLM_RST_DLY = 32'h0000_0064; // 1 s at 10 ms tick

  localparam logic [1:0] GLM_HTRANS_NONSEQ = 2'h2;

endpackage

//--- core/glm_tick_if.sv
/*
  Interface carrying the shared slow tick and level comparisons from the
  top module to the step manager.
  Assumes a single clock domain.
*/
`timescale 1ns/10ps
interface glm_tick_if;
  logic tick;          // One-cycle tick pulse
  logic below_add;     // Power below multi add level
  logic above_sub;     // Power above multi subtract level
  modport src (output tick, output below_add, output above_sub);
  modport dst (input tick, input below_add, input above_sub);
endinterface // glm_tick_if

//--- core/glm_step_mgr.sv
/*
  Five-step load manager: start delays, wait delays and 0.25 s pulses.
  Assumes the tick and level inputs from the top, all in the hclk domain.
*/
`timescale 1ns/10ps
module glm_step_mgr
  import glm_pkg::*;
#(
  parameter int STEPS = GLM_STEPS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Shared tick and levels
  glm_tick_if.dst ti,
  // Delays in ticks
  input wire logic [GLM_TW-1:0] add_start,
  input wire logic [GLM_TW-1:0] sub_start,
  input wire logic [GLM_TW-1:0] add_wait,
  input wire logic [GLM_TW-1:0] sub_wait,
  // Outputs
  output logic [STEPS-1:0] add_pulse,
  output logic [STEPS-1:0] sub_pulse,
  output logic [STEPS-1:0] connected
);

  // ==========================================================================
  // State
  logic [GLM_TW-1:0] ast_ff, nxt_ast;      // Add start timer
  logic [GLM_TW-1:0] sst_ff, nxt_sst;      // Subtract start timer
  logic [GLM_TW-1:0] awt_ff, nxt_awt;      // Ticks since last add
  logic [GLM_TW-1:0] swt_ff, nxt_swt;      // Ticks since last subtract
  logic [GLM_TW-1:0] pw_ff, nxt_pw;        // Pulse ticks left
  logic [STEPS-1:0] add_ff, nxt_add;
  logic [STEPS-1:0] sub_ff, nxt_sub;
  logic [STEPS-1:0] con_ff, nxt_con;

  // Saturating increment
  function automatic logic [GLM_TW-1:0] sat_inc(input logic [GLM_TW-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // Next-state: timers and step pulses
  always_comb begin
    nxt_ast = ast_ff;
    nxt_sst = sst_ff;
    nxt_awt = awt_ff;
    nxt_swt = swt_ff;
    nxt_pw = pw_ff;
    nxt_add = add_ff;
    nxt_sub = sub_ff;
    nxt_con = con_ff;
    if (ti.tick) begin
      // Start timers restart when the condition drops
      nxt_ast = ti.below_add ? sat_inc(ast_ff) : '0;
      nxt_sst = ti.above_sub ? sat_inc(sst_ff) : '0;
      nxt_awt = sat_inc(awt_ff);
      nxt_swt = sat_inc(swt_ff);
      if (pw_ff != '0) begin
        // Pulse running
        nxt_pw = pw_ff - 1'b1;
        if (pw_ff == GLM_TW'(1)) begin
          nxt_add = '0;
          nxt_sub = '0;
        end
      end else if (ti.below_add && ast_ff >= add_start && awt_ff >= add_wait && !(&con_ff)) begin
        // Lowest unconnected step goes on
        for (int i = STEPS - 1; i >= 0; i--) begin
          if (!con_ff[i]) begin
            nxt_add = '0;
            nxt_add[i] = 1'b1;
          end
        end
        nxt_con = con_ff | nxt_add;
        nxt_pw = GLM_TW'(GLM_PULSE_TICKS);
        nxt_ast = '0;
        nxt_awt = '0;
      end else if (ti.above_sub && sst_ff >= sub_start && swt_ff >= sub_wait && (|con_ff)) begin
        // Highest connected step goes off
        for (int i = 0; i < STEPS; i++) begin
          if (con_ff[i]) begin
            nxt_sub = '0;
            nxt_sub[i] = 1'b1;
          end
        end
        nxt_con = con_ff & ~nxt_sub;
        nxt_pw = GLM_TW'(GLM_PULSE_TICKS);
        nxt_sst = '0;
        nxt_swt = '0;
      end
    end
  end

  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ast_ff <= '0;
      sst_ff <= '0;
      awt_ff <= '1;
      swt_ff <= '1;
      pw_ff <= '0;
      add_ff <= '0;
      sub_ff <= '0;
      con_ff <= '0;
    end else begin
      ast_ff <= nxt_ast;
      sst_ff <= nxt_sst;
      awt_ff <= nxt_awt;
      swt_ff <= nxt_swt;
      pw_ff <= nxt_pw;
      add_ff <= nxt_add;
      sub_ff <= nxt_sub;
      con_ff <= nxt_con;
    end
  end

  assign add_pulse = add_ff;
  assign sub_pulse = sub_ff;
  assign connected = con_ff;

endmodule // glm_step_mgr

//--- core/glm_top.sv
/*
  Genset load management top: AHB-Lite register slave, load shedding and
  dummy load, add/subtract outputs with spacing delays, and step manager.
  Assumes one AHB-Lite master, single word transfers, 100 MHz hclk.
*/
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
module glm_top
  import glm_pkg::*;
#(
  parameter int TICK_CYC = GLM_TICK_CYC   // Cycles per delay tick
) (
  // AHB-Lite
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Load outputs
  output logic shed_out,
  output logic dummy_out,
  output logic add_out,
  output logic sub_out,
  output logic [GLM_STEPS-1:0] step_add,
  output logic [GLM_STEPS-1:0] step_sub
);

  // ==========================================================================
  // Bus slave state
  logic wr_ff, nxt_wr;                // Write data phase pending
  logic [7:0] wa_ff, nxt_wa;          // Latched write offset
  logic [31:0] rd_ff, nxt_rd;         // Read data
  logic [GLM_PW-1:0] pow_ff, nxt_pow;
  logic [GLM_PW-1:0] shi_ff, nxt_shi;
  logic [GLM_PW-1:0] slo_ff, nxt_slo;
  logic [GLM_TW-1:0] sdl_ff, nxt_sdl;
  logic [GLM_TW-1:0] cdl_ff, nxt_cdl;
  logic [GLM_PW-1:0] mal_ff, nxt_mal;
  logic [GLM_PW-1:0] msl_ff, nxt_msl;
  logic [GLM_TW-1:0] mas_ff, nxt_mas;
  logic [GLM_TW-1:0] mss_ff, nxt_mss;
  logic [GLM_TW-1:0] increase_wait_delay_ff, nxt_increase_wait_delay;
  logic [GLM_TW-1:0] decrease_wait_delay_ff, nxt_decrease_wait_delay;
  logic take;                         // Address phase accepted

  // ==========================================================================
  // Load logic state
  logic [31:0] div_ff, nxt_div;       // Tick divider
  logic tick_ff, nxt_tick;
  logic shed_ff, nxt_shed;
  logic dum_ff, nxt_dum;
  logic add_ff, nxt_add;
  logic sub_ff, nxt_sub;
  logic [GLM_TW-1:0] at_ff, nxt_at;   // Ticks since add activation
  logic [GLM_TW-1:0] st_ff, nxt_st;   // Ticks since subtract activation
  logic [GLM_STEPS-1:0] sa_ff, nxt_sa;
  logic [GLM_STEPS-1:0] ss_ff, nxt_ss;
  logic [GLM_STEPS-1:0] mgr_add, mgr_sub, mgr_con;

  glm_tick_if ti();

  // Saturating increment
  function automatic logic [GLM_TW-1:0] sat_inc(input logic [GLM_TW-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // Read mux for one offset
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [31:0] st);
    unique case (a)
      GLM_A_POWER: rd_mux = 32'(pow_ff);
      GLM_A_SHED_HI: rd_mux = 32'(shi_ff);
      GLM_A_SHED_LO: rd_mux = 32'(slo_ff);
      GLM_A_SAME_DLY: rd_mux = 32'(sdl_ff);
      GLM_A_CROSS_DLY: rd_mux = 32'(cdl_ff);
      GLM_A_MADD_LVL: rd_mux = 32'(mal_ff);
      GLM_A_MSUB_LVL: rd_mux = 32'(msl_ff);
      GLM_A_MADD_START: rd_mux = 32'(mas_ff);
      GLM_A_MSUB_START: rd_mux = 32'(mss_ff);
      GLM_A_MADD_WAIT: rd_mux = 32'(increase_wait_delay_ff);
      GLM_A_MSUB_WAIT: rd_mux = 32'(decrease_wait_delay_ff);
      GLM_A_STATUS: rd_mux = st;
      default: rd_mux = GLM_RST_ZERO;     // Unmapped reads zero
    endcase
  endfunction

  assign take = hsel && hready && (htrans == GLM_HTRANS_NONSEQ);

  // ==========================================================================
  // Bus slave next state: zero wait state, writes land in data phase
  always_comb begin
    logic [31:0] st;
    st = GLM_RST_ZERO;
    st[GLM_ST_SHED] = shed_ff;
    st[GLM_ST_DUMMY] = dum_ff;
    st[GLM_ST_ADD] = add_ff;
    st[GLM_ST_SUB] = sub_ff;
    st[GLM_ST_STEPS +: GLM_STEPS] = mgr_con;
    nxt_wr = take && hwrite;
    nxt_wa = take ? haddr[7:0] : wa_ff;
    nxt_rd = (take && !hwrite) ? rd_mux(haddr[7:0], st) : rd_ff;
    nxt_pow = pow_ff;
    nxt_shi = shi_ff;
    nxt_slo = slo_ff;
    nxt_sdl = sdl_ff;
    nxt_cdl = cdl_ff;
    nxt_mal = mal_ff;
    nxt_msl = msl_ff;
    nxt_mas = mas_ff;
    nxt_mss = mss_ff;
    nxt_increase_wait_delay = increase_wait_delay_ff;
    nxt_decrease_wait_delay = decrease_wait_delay_ff;
    if (wr_ff) begin
      // Write data phase
      unique case (wa_ff)
        GLM_A_POWER: nxt_pow = hwdata[GLM_PW-1:0];
        GLM_A_SHED_HI: nxt_shi = hwdata[GLM_PW-1:0];
        GLM_A_SHED_LO: nxt_slo = hwdata[GLM_PW-1:0];
        GLM_A_SAME_DLY: nxt_sdl = hwdata[GLM_TW-1:0];
        GLM_A_CROSS_DLY: nxt_cdl = hwdata[GLM_TW-1:0];
        GLM_A_MADD_LVL: nxt_mal = hwdata[GLM_PW-1:0];
        GLM_A_MSUB_LVL: nxt_msl = hwdata[GLM_PW-1:0];
        GLM_A_MADD_START: nxt_mas = hwdata[GLM_TW-1:0];
        GLM_A_MSUB_START: nxt_mss = hwdata[GLM_TW-1:0];
        GLM_A_MADD_WAIT: nxt_increase_wait_delay = hwdata[GLM_TW-1:0];
        GLM_A_MSUB_WAIT: nxt_decrease_wait_delay = hwdata[GLM_TW-1:0];
        default: ;                        // Status and unmapped ignore writes
      endcase
    end
  end

  // Bus slave registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      wa_ff <= '0;
      rd_ff <= GLM_RST_ZERO;
      pow_ff <= '0;
      shi_ff <= GLM_RST_HI[GLM_PW-1:0];
      slo_ff <= '0;
      sdl_ff <= GLM_RST_DLY[GLM_TW-1:0];
      cdl_ff <= GLM_RST_DLY[GLM_TW-1:0];
      mal_ff <= '0;
      msl_ff <= GLM_RST_HI[GLM_PW-1:0];
      mas_ff <= GLM_RST_DLY[GLM_TW-1:0];
      mss_ff <= GLM_RST_DLY[GLM_TW-1:0];
      increase_wait_delay_ff <= GLM_RST_DLY[GLM_TW-1:0];
      decrease_wait_delay_ff <= GLM_RST_DLY[GLM_TW-1:0];
    end else begin
      wr_ff <= nxt_wr;
      wa_ff <= nxt_wa;
      rd_ff <= nxt_rd;
      pow_ff <= nxt_pow;
      shi_ff <= nxt_shi;
      slo_ff <= nxt_slo;
      sdl_ff <= nxt_sdl;
      cdl_ff <= nxt_cdl;
      mal_ff <= nxt_mal;
      msl_ff <= nxt_msl;
      mas_ff <= nxt_mas;
      mss_ff <= nxt_mss;
      increase_wait_delay_ff <= nxt_increase_wait_delay;
      decrease_wait_delay_ff <= nxt_decrease_wait_delay;
    end
  end

  assign hrdata = rd_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================================================
  // Load logic next state: runs always, no enable
  always_comb begin
    nxt_tick = (div_ff == 32'(TICK_CYC - 1));
    nxt_div = nxt_tick ? '0 : div_ff + 1'b1;
    nxt_at = at_ff;
    nxt_st = st_ff;
    nxt_add = add_ff;
    nxt_sub = sub_ff;
    // Hysteretic shed, no enable bit
    if (pow_ff > shi_ff) begin
      nxt_shed = 1'b1;
    end else if (pow_ff < slo_ff) begin
      nxt_shed = 1'b0;
    end else begin
      nxt_shed = shed_ff;
    end
    nxt_dum = ~nxt_shed;
    if (tick_ff) begin
      nxt_at = sat_inc(at_ff);
      nxt_st = sat_inc(st_ff);
    end
    // Add output
    if (pow_ff >= slo_ff) begin
      nxt_add = 1'b0;
    end else if (!add_ff && at_ff >= sdl_ff && st_ff >= cdl_ff) begin
      nxt_add = 1'b1;
      nxt_at = '0;
    end
    // Subtract output
    if (pow_ff <= shi_ff) begin
      nxt_sub = 1'b0;
    end else if (!sub_ff && st_ff >= sdl_ff) begin
      nxt_sub = 1'b1;
      nxt_st = '0;
    end
    nxt_sa = mgr_add;
    nxt_ss = mgr_sub;
  end

  // Load logic registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
      shed_ff <= 1'b0;
      dum_ff <= 1'b1;
      add_ff <= 1'b0;
      sub_ff <= 1'b0;
      at_ff <= '1;
      st_ff <= '1;
      sa_ff <= '0;
      ss_ff <= '0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
      shed_ff <= nxt_shed;
      dum_ff <= nxt_dum;
      add_ff <= nxt_add;
      sub_ff <= nxt_sub;
      at_ff <= nxt_at;
      st_ff <= nxt_st;
      sa_ff <= nxt_sa;
      ss_ff <= nxt_ss;
    end
  end

  assign ti.tick = tick_ff;
  assign ti.below_add = pow_ff < mal_ff;
  assign ti.above_sub = pow_ff > msl_ff;

  // Step manager
  glm_step_mgr #(.STEPS(GLM_STEPS)) u_steps (
    .hclk(hclk),
    .hresetn(hresetn),
    .ti(ti),
    .add_start(mas_ff),
    .sub_start(mss_ff),
    .add_wait(increase_wait_delay_ff),
    .sub_wait(decrease_wait_delay_ff),
    .add_pulse(mgr_add),
    .sub_pulse(mgr_sub),
    .connected(mgr_con)
  );

  assign shed_out = shed_ff;
  assign dummy_out = dum_ff;
  assign add_out = add_ff;
  assign sub_out = sub_ff;
  assign step_add = sa_ff;
  assign step_sub = ss_ff;

endmodule // glm_top

//--- verif/glm_checker.sv
/*
  Checker for the load management top: shedding, add/subtract levels, step pulses.
  Assumes bind to glm_top and a register shadow kept from observed bus writes.
*/
`timescale 1ns/10ps
module glm_checker
  import glm_pkg::*;
#(
  parameter int TICK_CYC = GLM_TICK_CYC  // Cycles per delay tick
) (
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  // Load outputs
  input wire logic shed_out,
  input wire logic dummy_out,
  input wire logic add_out,
  input wire logic sub_out,
  input wire logic [GLM_STEPS-1:0] step_add,
  input wire logic [GLM_STEPS-1:0] step_sub
);
  // ==========================================================================
  // Shadow of power and limits, pulse length counter
  localparam int PLO = (GLM_PULSE_TICKS - 1) * TICK_CYC + 1;  // Shortest legal pulse
  localparam int PHI = GLM_PULSE_TICKS * TICK_CYC + 1;        // Longest legal pulse
  logic wr_ff, nxt_wr;                            // Write address phase seen
  logic [7:0] wa_ff, nxt_wa;                      // Its offset
  logic [GLM_PW-1:0] pw_ff, hi_ff, lo_ff;         // Shadow registers
  logic [GLM_PW-1:0] nxt_pw, nxt_hi, nxt_lo;
  int cnt_ff, nxt_cnt;                            // Cycles a step pulse stands
  logic pact;                                     // Any step pulse high
  assign pact = |{step_add, step_sub};
  // Next values of the shadow
  always_comb begin
    nxt_wr = hsel & hready & (htrans == GLM_HTRANS_NONSEQ) & hwrite;
    nxt_wa = haddr[7:0];
    nxt_pw = (wr_ff && wa_ff == GLM_A_POWER) ? hwdata[GLM_PW-1:0] : pw_ff;
    nxt_hi = (wr_ff && wa_ff == GLM_A_SHED_HI) ? hwdata[GLM_PW-1:0] : hi_ff;
    nxt_lo = (wr_ff && wa_ff == GLM_A_SHED_LO) ? hwdata[GLM_PW-1:0] : lo_ff;
    nxt_cnt = pact ? cnt_ff + 1 : 0;
  end
  // Registers of the shadow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      wa_ff <= 8'h00;
      pw_ff <= GLM_RST_ZERO[GLM_PW-1:0];
      hi_ff <= GLM_RST_HI[GLM_PW-1:0];
      lo_ff <= GLM_RST_ZERO[GLM_PW-1:0];
      cnt_ff <= 0;
    end else begin
      wr_ff <= nxt_wr;
      wa_ff <= nxt_wa;
      pw_ff <= nxt_pw;
      hi_ff <= nxt_hi;
      lo_ff <= nxt_lo;
      cnt_ff <= nxt_cnt;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_dummy_inv; dummy_out == !shed_out; endproperty
  a_dummy_inv: assert property (p_dummy_inv) else $error("dummy not inverse of shed");
  property p_shed_set; (pw_ff > hi_ff) |-> ##1 shed_out; endproperty
  a_shed_set: assert property (p_shed_set) else $error("shed not set above upper limit");
  property p_shed_rise; $rose(shed_out) |-> $past(pw_ff) > $past(hi_ff); endproperty
  a_shed_rise: assert property (p_shed_rise) else $error("shed rose without cause");
  property p_shed_fall; $fell(shed_out) |-> $past(pw_ff) < $past(lo_ff); endproperty
  a_shed_fall: assert property (p_shed_fall) else $error("shed fell above lower limit");
  property p_add_cause; add_out |-> $past(pw_ff) < $past(lo_ff); endproperty
  a_add_cause: assert property (p_add_cause) else $error("add active not below limit");
  property p_sub_cause; sub_out |-> $past(pw_ff) > $past(hi_ff); endproperty
  a_sub_cause: assert property (p_sub_cause) else $error("sub active not above limit");
  property p_one_step; $onehot0({step_add, step_sub}); endproperty
  a_one_step: assert property (p_one_step) else $error("more than one step pulse");
  property p_pulse_hold; pact && $past(pact) |-> $stable({step_add, step_sub}); endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("step pulse changed");
  property p_pulse_len; $fell(pact) |-> (cnt_ff >= PLO) && (cnt_ff <= PHI); endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("step pulse length wrong");
  // Main scenarios reached
  c_shed: cover property ($rose(shed_out));
  c_step_add: cover property ($rose(|step_add));
  c_step_sub: cover property ($rose(|step_sub));
endmodule // glm_checker

bind glm_top glm_checker #(.TICK_CYC(TICK_CYC)) u_glm_checker (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .shed_out, .dummy_out, .add_out, .sub_out, .step_add, .step_sub);

//--- verif/glm_load_bank.sv
/*
  Model of the multi-step load banks: a step pulse connects or drops one bank.
  Assumes one-hot pulses in the hclk domain.
*/
`timescale 1ns/10ps
module glm_load_bank
  import glm_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Relay pulses
  input wire logic [GLM_STEPS-1:0] step_add,
  input wire logic [GLM_STEPS-1:0] step_sub,
  // Banks now supplied
  output logic [GLM_STEPS-1:0] banks
);
  logic [GLM_STEPS-1:0] bank_ff, nxt_bank;  // Bank contactors
  logic [GLM_STEPS-1:0] add_ff, sub_ff;     // Last pulse levels
  assign banks = bank_ff;
  // A rising pulse latches or releases its contactor
  always_comb begin
    nxt_bank = (bank_ff | (step_add & ~add_ff)) & ~(step_sub & ~sub_ff);
  end
  // Contactor state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank_ff <= '0;
      add_ff <= '0;
      sub_ff <= '0;
    end else begin
      bank_ff <= nxt_bank;
      add_ff <= step_add;
      sub_ff <= step_sub;
    end
  end
endmodule // glm_load_bank

//--- verif/tb_top.sv
/*
  Testbench for glm_top: register access, shedding, add/subtract spacing, steps.
  Assumes a short tick parameter and an AHB-Lite master driven from tasks.
*/
`timescale 1ns/10ps
module tb_top;
  import glm_pkg::*;
  // ==========================================================================
  // Signals
  localparam int TC = 4;  // Cycles per tick in simulation
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic shed_out, dummy_out, add_out, sub_out;
  logic [GLM_STEPS-1:0] step_add, step_sub, banks;
  int n_errors, checked;
  logic [7:0] ra [6] = '{GLM_A_SHED_HI, GLM_A_SHED_LO, GLM_A_SAME_DLY, GLM_A_MSUB_LVL, GLM_A_MADD_WAIT, GLM_A_STATUS};
  logic [31:0] rv [6] = '{GLM_RST_HI, GLM_RST_ZERO, GLM_RST_DLY, GLM_RST_HI, GLM_RST_DLY, 32'h0000_0002};
  assign hready = hreadyout;
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
  // ==========================================================================
  // Design and load banks
  glm_top #(.TICK_CYC(TC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .shed_out(shed_out), .dummy_out(dummy_out), .add_out(add_out), .sub_out(sub_out),
    .step_add(step_add), .step_sub(step_sub));
  glm_load_bank u_bank (.hclk(hclk), .hresetn(hresetn), .step_add(step_add), .step_sub(step_sub), .banks(banks));
  always #5 hclk = ~hclk;
  // ==========================================================================
  // Bus and wait helpers
  task automatic bus_wait;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= GLM_HTRANS_NONSEQ;
    hwrite <= wr;
    bus_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait();
    q = hrdata;
    `CHK(hresp, 1'b0)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    ahb(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // Cycles from the call to the start of the next step pulse
  task automatic wait_pulse(output logic [4:0] a, output logic [4:0] s, output int c);
    c = 0;
    while ((step_add | step_sub) !== 5'h00 && c < 3000) begin
      settle(1);
      c++;
    end
    while ((step_add | step_sub) === 5'h00 && c < 3000) begin
      settle(1);
      c++;
    end
    a = step_add;
    s = step_sub;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] q;
    `CHK(dummy_out, 1'b1)
    `CHK({shed_out, add_out, sub_out, step_add, step_sub}, 13'h0000)
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], q);
      `CHK(q, rv[i])
    end
    wr(GLM_A_STATUS, 32'hFFFF_FFFF);
    rd(GLM_A_STATUS, q);
    `CHK(q, 32'h0000_0002)
    rd(8'h40, q);
    `CHK(q, 32'h0000_0000)
    wr(GLM_A_CROSS_DLY, 32'hFFFF_FFFF);
    rd(GLM_A_CROSS_DLY, q);
    `CHK(q, 32'h00FF_FFFF)
    $display("test reset done");
  endtask
  task automatic t_shed;
    wr(GLM_A_SAME_DLY, 32'h0000_000A);
    wr(GLM_A_CROSS_DLY, 32'h0000_0014);
    wr(GLM_A_SHED_HI, 32'h0000_03E8);
    wr(GLM_A_SHED_LO, 32'h0000_01F4);
    wr(GLM_A_POWER, 32'h0000_04B0);
    settle(2);
    `CHK(shed_out, 1'b1)
    `CHK(dummy_out, 1'b0)
    `CHK(sub_out, 1'b1)
    wr(GLM_A_POWER, 32'h0000_02BC);
    settle(2);
    `CHK(shed_out, 1'b1)
    `CHK(sub_out, 1'b0)
    wr(GLM_A_POWER, 32'h0000_0190);
    settle(2);
    `CHK(shed_out, 1'b0)
    `CHK(dummy_out, 1'b1)
    `CHK(add_out, 1'b0)
    settle(22 * TC);
    `CHK(add_out, 1'b1)
    $display("test shed done");
  endtask
  task automatic t_same;
    wr(GLM_A_POWER, 32'h0000_0258);
    settle(2);
    `CHK(add_out, 1'b0)
    wr(GLM_A_POWER, 32'h0000_0190);
    settle(2);
    `CHK(add_out, 1'b0)
    settle(12 * TC);
    `CHK(add_out, 1'b1)
    wr(GLM_A_POWER, 32'h0000_05DC);
    settle(2);
    `CHK(sub_out, 1'b1)
    wr(GLM_A_POWER, 32'h0000_02BC);
    settle(2);
    `CHK(sub_out, 1'b0)
    wr(GLM_A_POWER, 32'h0000_05DC);
    settle(2);
    `CHK(sub_out, 1'b0)
    settle(12 * TC);
    `CHK(sub_out, 1'b1)
    wr(GLM_A_POWER, 32'h0000_02BC);
    $display("test same done");
  endtask
  task automatic t_steps;
    logic [4:0] a, s, acc;
    logic [31:0] q;
    int c;
    wr(GLM_A_MADD_LVL, 32'h0000_012C);
    wr(GLM_A_MSUB_LVL, 32'h0000_07D0);
    wr(GLM_A_MADD_START, 32'h0000_0005);
    wr(GLM_A_MSUB_START, 32'h0000_0005);
    wr(GLM_A_MADD_WAIT, 32'h0000_001E);
    wr(GLM_A_MSUB_WAIT, 32'h0000_001E);
    wr(GLM_A_POWER, 32'h0000_00C8);
    settle(3 * TC);
    wr(GLM_A_POWER, 32'h0000_02BC);
    // Hold power high across at least one tick so the start timer restarts
    settle(2 * TC);
    wr(GLM_A_POWER, 32'h0000_00C8);
    wait_pulse(a, s, c);
    `CHK(a, 5'h01)
    `CHK(c >= 4 * TC, 1'b1)
    for (int i = 1; i < 5; i++) begin
      wait_pulse(a, s, c);
      `CHK(a, 5'h01 << i)
      `CHK(c >= 29 * TC, 1'b1)
    end
    settle(30 * TC);
    acc = 5'h00;
    repeat (60 * TC) begin
      settle(1);
      acc = acc | step_add;
    end
    `CHK(acc, 5'h00)
    `CHK(banks, 5'h1F)
    rd(GLM_A_STATUS, q);
    `CHK(q[12:8], 5'h1F)
    wr(GLM_A_POWER, 32'h0000_09C4);
    for (int i = 4; i >= 0; i--) begin
      wait_pulse(a, s, c);
      `CHK({a, s}, {5'h00, 5'h01 << i})
      if (i < 4) `CHK(c >= 29 * TC, 1'b1)
    end
    settle(30 * TC);
    `CHK(banks, 5'h00)
    $display("test steps done");
  endtask
  // ==========================================================================
  // Verdict, main sequence and watchdog
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    n_errors = 0;
    checked = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    t_reset();
    t_shed();
    t_same();
    t_steps();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    complete_run();
  end
endmodule // tb_top
